// File: isrp_params.svh
// constants of the image sensor readout port: geometry, register map, field positions
// What this block does
// (R1) Partner supplies 26.6 MHz master clock; the bench partner toggles every 32 ns, 15.625 MHz
// (R2) Line sync drives in master, listens in slave
// (R3) Frame sync drives in master, listens in slave
// (R4) Line and frame valid only with data
// (R5) Data valid at pixel clock rising edge
// (R6) Pixel bus ten bits, bit 0 to 9
// (R7) Output enable low floats only data pins
// (R8) Differential serial data with shift clock
// (R9) Array is 782 columns by 492 rows
// (R10) Left 26 columns, top 8 rows black
// (R11) Black rows drive automatic black level
// (R12) Raw mode also outputs middle four black rows
// (R13) Active region 753 columns by 481 rows
// (R14) Extra active column, row for mirroring
// (R15) Binning mixes immediate neighbours only
// (R16) Interlaced fields split red and blue rows
// (R17) Colour bit: first green offset for all
// (R18) Colour bit clear: all dark pixels
// (R19) One pixel word each pixel clock period
// (R20) Pixel clock toggles during blanking too
// (R21) Receiver captures only when both valids high
`ifndef ISRP_PARAMS_SVH
`define ISRP_PARAMS_SVH
`define ISRP_PIX_W         10
`define ISRP_NCOLS         10'h30E
`define ISRP_NROWS         9'h1EC
`define ISRP_BLK_COLS      10'h01A
`define ISRP_BLK_ROWS      9'h008
`define ISRP_RAW_ROW0      9'h002
`define ISRP_RAW_ROWS      9'h004
`define ISRP_ACT_COLS      10'h2F1
`define ISRP_ACT_ROWS      10'h1E1
`define ISRP_ACT_COL0      10'h01C
`define ISRP_ACT_ROW0      10'h009
`define ISRP_CAL_LAST      9'h0FF
`define ISRP_SER_BITS      4'hB
`define ISRP_REG_CTRL      8'h00
`define ISRP_REG_BLC       8'h0F
`define ISRP_REG_STAT      8'h10
`define ISRP_REG_FCNT      8'h11
`define ISRP_CTRL_RESET    7'h41
`define ISRP_BLC_COLOUR    2
`define ISRP_STAT_OVR      15
`endif

// File: isrp_partner.sv
// behavioural capture controller: master clock, pixel source and line receiver
`timescale 1ns/1ps
module isrp_partner (
  input  wire logic                sys_clk,
  input  wire logic                clk_run,
  input  wire logic [8:0]          arr_row,
  input  wire logic [9:0]          arr_col,
  input  wire isrp_pkg::isrp_pix_t pix,
  input  wire logic                pixel_clock_out,
  output logic                     master_clock_in,
  output logic [9:0]               adc_data,
  output logic [15:0]              line_len,
  output logic [3:0]               row_tag,
  output logic [15:0]              seq_err
);
  import isrp_pkg::*;
  logic [15:0] cur_len;
  logic        pck_q;
  isrp_pix_t   pix_q;
  logic [9:0]  prev;

  // master clock held still until the bench has configured the port
  initial begin
    master_clock_in = 1'b0;
    cur_len = 16'h0000;
    line_len = 16'h0000;
    row_tag = 4'h0;
    seq_err = 16'h0000;
    #3;
    forever begin
      #32;
      if (clk_run) master_clock_in = ~master_clock_in;
    end
  end

  // rows 0 and 1 alternate two levels so each class mean is known exactly;
  // later rows carry row and column bits so the receiver can check order
  always_comb begin
    if (arr_row < 9'h002) adc_data = arr_col[0] ? 10'h040 : 10'h020;
    else adc_data = {arr_row[3:0], arr_col[5:0]};
  end

  // sample on the pixel clock rise, only while both valids are high
  always @(posedge sys_clk) begin
    pck_q <= pixel_clock_out;
    pix_q <= pix;
    if (!pix.lval && cur_len != 16'h0000) begin
      line_len <= cur_len;
      cur_len  <= 16'h0000;
    end
    if (pixel_clock_out && !pck_q && pix.lval && pix.fval) begin
      cur_len <= cur_len + 16'h0001;
      prev    <= pix.data;
      if (cur_len == 16'h0000) row_tag <= pix.data[9:6];
      // a missing or doubled word breaks the column step; a changing bus breaks hold
      if ((cur_len != 16'h0000 && pix.data !== {prev[9:6], prev[5:0] + 6'h01}) ||
          pix !== pix_q) seq_err <= seq_err + 16'h0001;
    end
  end
endmodule

// File: isrp_pkg.sv
// types shared by the image sensor readout port
package isrp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_SCAN  = 2'h1,
    ST_WLINE = 2'h3,
    ST_WFRM  = 2'h2
  } isrp_state_t;

  typedef struct packed {
    logic       en;
    logic       ilace;
    logic       bin2;
    logic       mir_r;
    logic       mir_c;
    logic       raw;
    logic       master;
  } isrp_ctrl_t;

  typedef struct packed {
    logic       lval;
    logic       fval;
    logic [9:0] data;
  } isrp_pix_t;
endpackage

// File: isrp_top.sv
// readout sequencer, black level, parallel and serial pixel output of the sensor
`timescale 1ns/1ps
`include "isrp_params.svh"
module isrp_top (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              master_clock_in,
  input  wire logic              out_enable,
  input  wire logic              line_start_sync_i,
  input  wire logic              frame_start_sync_i,
  input  wire logic [9:0]        adc_data,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  output isrp_pkg::isrp_pix_t    pix,
  output logic                   pixel_clock_out,
  output logic                   pix_data_oe,
  output logic                   line_start_sync_o,
  output logic                   line_start_sync_oe,
  output logic                   frame_start_sync_o,
  output logic                   frame_start_sync_oe,
  output logic                   serial_pixel_out_p,
  output logic                   serial_pixel_out_n,
  output logic                   serial_shift_clock_p,
  output logic                   serial_shift_clock_n,
  output logic [8:0]             arr_row,
  output logic [9:0]             arr_col
);
  import isrp_pkg::*;

  // window test; mirrored readout starts one further in, on the spare pixel
  function automatic logic in_win(input logic [9:0] p, input logic [9:0] base,
                                  input logic [9:0] len, input logic mir);
    logic [9:0] top;
    top = base + len;
    in_win = mir ? (p > base && p <= top) : (p >= base && p < top);
  endfunction

  // clamp at zero so dark pixels never wrap
  function automatic logic [9:0] sub_sat(input logic [9:0] a, input logic [9:0] b);
    sub_sat = (a > b) ? a - b : 10'h000;
  endfunction

  // synchronisers: first stage is read only by the second
  logic mclk_s1_ff, mclk_s2_ff, mclk_s3_ff, oe_s1_ff, oe_s2_ff;
  logic ls_s1_ff, ls_s2_ff, ls_s3_ff, fs_s1_ff, fs_s2_ff, fs_s3_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      {mclk_s1_ff, mclk_s2_ff, mclk_s3_ff} <= 3'h0;
      {oe_s1_ff, oe_s2_ff} <= 2'h0;
      {ls_s1_ff, ls_s2_ff, ls_s3_ff} <= 3'h0;
      {fs_s1_ff, fs_s2_ff, fs_s3_ff} <= 3'h0;
    end else begin
      {mclk_s3_ff, mclk_s2_ff, mclk_s1_ff} <= {mclk_s2_ff, mclk_s1_ff, master_clock_in};
      {oe_s2_ff, oe_s1_ff} <= {oe_s1_ff, out_enable};
      {ls_s3_ff, ls_s2_ff, ls_s1_ff} <= {ls_s2_ff, ls_s1_ff, line_start_sync_i};
      {fs_s3_ff, fs_s2_ff, fs_s1_ff} <= {fs_s2_ff, fs_s1_ff, frame_start_sync_i};
    end
  end

  logic ev;
  assign ev = mclk_s2_ff & ~mclk_s3_ff;  // one array step per master rising edge [R1]

  // register bus
  isrp_ctrl_t  ctrl_ff, nxt_ctrl;
  logic        colour_ff, nxt_colour;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        ovr_ff, nxt_ovr, ovr_clr;
  logic [9:0]  off_ff, nxt_off;
  logic [15:0] fcnt_ff, nxt_fcnt;
  always_comb begin
    nxt_ctrl   = ctrl_ff;
    nxt_colour = colour_ff;
    nxt_rdata  = 16'h0000;
    ovr_clr    = 1'b0;
    if (reg_wr && reg_addr == `ISRP_REG_CTRL) nxt_ctrl = isrp_ctrl_t'(reg_wdata[6:0]);
    if (reg_wr && reg_addr == `ISRP_REG_BLC) nxt_colour = reg_wdata[`ISRP_BLC_COLOUR];
    if (reg_rd) begin
      unique case (reg_addr)
        `ISRP_REG_CTRL: nxt_rdata = {9'h000, ctrl_ff};
        `ISRP_REG_BLC:  nxt_rdata = {13'h0000, colour_ff, 2'h0};
        `ISRP_REG_STAT: begin
          nxt_rdata = {ovr_ff, 5'h00, off_ff};
          ovr_clr   = 1'b1;
        end
        `ISRP_REG_FCNT: nxt_rdata = fcnt_ff;
        default:        nxt_rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_ff   <= isrp_ctrl_t'(`ISRP_CTRL_RESET);
      colour_ff <= 1'b0;
      rdata_ff  <= 16'h0000;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      colour_ff <= nxt_colour;
      rdata_ff  <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;

  // array scan, black level and pixel output
  isrp_state_t state_ff, nxt_state;
  logic [9:0]  sc_col_ff, nxt_col, phys_col;
  logic [8:0]  sc_row_ff, nxt_row, phys_row;
  logic        field_ff, nxt_field, pt_ff, nxt_pt, hv_ff, nxt_hv;
  logic [9:0]  hold_ff, nxt_hold, val, emit_val;
  isrp_pix_t   pix_ff, nxt_pix;
  logic        ls_o_ff, nxt_ls, fs_o_ff, nxt_fs, ls_seen_ff, fs_seen_ff;
  logic [17:0] acc_ff, nxt_acc;
  logic [8:0]  cnt_ff, nxt_cnt;
  logic        emit, ls_take, fs_take, row_act, row_raw, win, is_blk, cal_q;
  logic [10:0] pair;

  assign phys_col = ctrl_ff.mir_c ? `ISRP_NCOLS - 10'h001 - sc_col_ff : sc_col_ff;  // [R14]
  assign phys_row = ctrl_ff.mir_r ? `ISRP_NROWS - 9'h001 - sc_row_ff : sc_row_ff;
  assign is_blk   = phys_row < `ISRP_BLK_ROWS || phys_col < `ISRP_BLK_COLS;  // [R10]
  // first green sits on even rows, odd columns
  assign cal_q = is_blk && !cnt_ff[8] &&
                 (!colour_ff || (!phys_row[0] && phys_col[0]));  // [R17] [R18]
  assign row_act = in_win({1'b0, phys_row}, `ISRP_ACT_ROW0, `ISRP_ACT_ROWS - 10'h001,
                          ctrl_ff.mir_r) &&
                   (!ctrl_ff.ilace || phys_row[0] == field_ff);  // [R13] [R14] [R16]
  assign row_raw = ctrl_ff.raw && phys_row >= `ISRP_RAW_ROW0 &&
                   phys_row < `ISRP_RAW_ROW0 + `ISRP_RAW_ROWS;  // [R12]
  assign win  = (row_act || row_raw) &&
                in_win(phys_col, `ISRP_ACT_COL0, `ISRP_ACT_COLS - 10'h001, ctrl_ff.mir_c);
  assign val  = row_act ? sub_sat(adc_data, off_ff) : adc_data;  // raw black rows uncorrected [R11]
  assign pair = {1'b0, hold_ff} + {1'b0, val};

  always_comb begin
    nxt_state = state_ff;
    nxt_col   = sc_col_ff;
    nxt_row   = sc_row_ff;
    nxt_field = field_ff;
    nxt_pt    = pt_ff;
    nxt_hv    = hv_ff;
    nxt_hold  = hold_ff;
    nxt_pix   = pix_ff;
    nxt_ls    = ls_o_ff;
    nxt_fs    = fs_o_ff;
    nxt_acc   = acc_ff;
    nxt_cnt   = cnt_ff;
    nxt_off   = off_ff;
    nxt_fcnt  = fcnt_ff;
    emit      = 1'b0;
    emit_val  = 10'h000;
    ls_take   = 1'b0;
    fs_take   = 1'b0;
    // all scan and pixel changes land on a master edge so data is steady across the pixel clock rise when bin2 is clear
    if (ev) begin
      nxt_pt = ~pt_ff;
      nxt_ls = 1'b0;
      nxt_fs = 1'b0;
      if (!ctrl_ff.en) begin
        nxt_state = ST_IDLE;
        nxt_pix   = '0;
        nxt_hv    = 1'b0;
      end else begin
        unique case (state_ff)
          ST_IDLE: begin
            nxt_col = 10'h000;
            nxt_row = 9'h000;
            nxt_acc = 18'h00000;
            nxt_cnt = 9'h000;
            if (ctrl_ff.master) begin
              nxt_state = ST_SCAN;
              nxt_ls    = 1'b1;  // [R2]
              nxt_fs    = 1'b1;  // [R3]
            end else begin
              nxt_state = ST_WFRM;
            end
          end
          ST_WLINE: if (ls_seen_ff) begin
            nxt_state = ST_SCAN;  // slave row starts on the partner's line sync [R2]
            ls_take   = 1'b1;
          end
          ST_WFRM: if (fs_seen_ff) begin
            nxt_state = ST_SCAN;  // [R3]
            fs_take   = 1'b1;
          end
          ST_SCAN: begin
            if (cal_q) begin
              nxt_acc = acc_ff + {8'h00, adc_data};
              nxt_cnt = cnt_ff + 9'h001;
              if (cnt_ff == `ISRP_CAL_LAST) nxt_off = nxt_acc[17:8];  // mean of 256 [R11]
            end
            if (win) begin
              if (!ctrl_ff.bin2) begin
                emit     = 1'b1;
                emit_val = val;
              end else if (!pt_ff) begin
                nxt_hold = val;
                nxt_hv   = 1'b1;
              end else if (hv_ff) begin
                emit     = 1'b1;
                emit_val = pair[10:1];  // plain neighbour average, colours mix [R15]
                nxt_hv   = 1'b0;
              end
            end else begin
              nxt_pix.lval = 1'b0;  // [R4]
              nxt_pix.data = 10'h000;
              nxt_hv       = 1'b0;
            end
            if (emit) begin
              nxt_pix.data = emit_val;  // [R6] [R19]
              nxt_pix.lval = 1'b1;
              nxt_pix.fval = 1'b1;
            end
            if (sc_col_ff == `ISRP_NCOLS - 10'h001) begin
              nxt_col = 10'h000;  // [R9]
              if (sc_row_ff == `ISRP_NROWS - 9'h001) begin
                nxt_row      = 9'h000;
                nxt_pix.fval = 1'b0;
                nxt_field    = ~field_ff;  // [R16]
                nxt_fcnt     = fcnt_ff + 16'h0001;
                nxt_acc      = 18'h00000;
                nxt_cnt      = 9'h000;
                nxt_ls       = ctrl_ff.master;
                nxt_fs       = ctrl_ff.master;
                if (!ctrl_ff.master) nxt_state = ST_WFRM;
              end else begin
                nxt_row = sc_row_ff + 9'h001;
                nxt_ls  = ctrl_ff.master;
                if (!ctrl_ff.master) nxt_state = ST_WLINE;
              end
            end else begin
              nxt_col = sc_col_ff + 10'h001;
            end
          end
          default: nxt_state = ST_IDLE;
        endcase
      end
    end
    // a slave never drives the sync pins, even when master is cleared mid-pulse
    if (!ctrl_ff.master) begin
      nxt_ls = 1'b0;  // [R2]
      nxt_fs = 1'b0;  // [R3]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      sc_col_ff  <= 10'h000;
      sc_row_ff  <= 9'h000;
      field_ff   <= 1'b0;
      pt_ff      <= 1'b0;
      hv_ff      <= 1'b0;
      hold_ff    <= 10'h000;
      pix_ff     <= '0;
      ls_o_ff    <= 1'b0;
      fs_o_ff    <= 1'b0;
      acc_ff     <= 18'h00000;
      cnt_ff     <= 9'h000;
      off_ff     <= 10'h000;
      fcnt_ff    <= 16'h0000;
      ls_seen_ff <= 1'b0;
      fs_seen_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      sc_col_ff  <= nxt_col;
      sc_row_ff  <= nxt_row;
      field_ff   <= nxt_field;
      pt_ff      <= nxt_pt;
      hv_ff      <= nxt_hv;
      hold_ff    <= nxt_hold;
      pix_ff     <= nxt_pix;
      ls_o_ff    <= nxt_ls;
      fs_o_ff    <= nxt_fs;
      acc_ff     <= nxt_acc;
      cnt_ff     <= nxt_cnt;
      off_ff     <= nxt_off;
      fcnt_ff    <= nxt_fcnt;
      // an edge in the cycle it is taken is kept; master mode ignores the pins
      ls_seen_ff <= !ctrl_ff.master && ((ls_s2_ff & ~ls_s3_ff) | (ls_seen_ff & ~ls_take));
      fs_seen_ff <= !ctrl_ff.master && ((fs_s2_ff & ~fs_s3_ff) | (fs_seen_ff & ~fs_take));
    end
  end

  // pin drivers; only the data pins follow the output enable
  logic pclk_ff, doe_ff, lsoe_ff, fsoe_ff;
  logic [8:0] arow_ff;
  logic [9:0] acol_ff;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pclk_ff <= 1'b0;
      doe_ff  <= 1'b0;
      lsoe_ff <= 1'b0;
      fsoe_ff <= 1'b0;
      arow_ff <= 9'h000;
      acol_ff <= 10'h000;
    end else begin
      pclk_ff <= ctrl_ff.bin2 ? nxt_pt : ~mclk_s2_ff;  // free running [R5] [R20]
      doe_ff  <= oe_s2_ff;  // [R7]
      lsoe_ff <= ctrl_ff.master;  // [R2]
      fsoe_ff <= ctrl_ff.master;  // [R3]
      arow_ff <= phys_row;
      acol_ff <= phys_col;
    end
  end
  assign pix                 = pix_ff;
  assign pixel_clock_out     = pclk_ff;
  assign pix_data_oe         = doe_ff;
  assign line_start_sync_o   = ls_o_ff;
  assign line_start_sync_oe  = lsoe_ff;
  assign frame_start_sync_o  = fs_o_ff;
  assign frame_start_sync_oe = fsoe_ff;
  assign arr_row             = arow_ff;
  assign arr_col             = acol_ff;

  // serial: start bit then data lsb first, a bit per two sys_clk, clock edge mid-bit
  // a word arriving while one is still shifting is dropped and flagged
  logic [10:0] sh_ff, nxt_sh;
  logic [3:0]  scnt_ff, nxt_scnt;
  logic        ser_ff, nxt_ser, ph_ff, sck_ff;
  always_comb begin
    nxt_sh   = sh_ff;
    nxt_scnt = scnt_ff;
    nxt_ser  = ser_ff;
    nxt_ovr  = ovr_ff & ~ovr_clr;
    if (!ph_ff) begin
      nxt_ser = (scnt_ff != 4'h0) & sh_ff[0];
      if (scnt_ff != 4'h0) begin
        nxt_sh   = {1'b0, sh_ff[10:1]};
        nxt_scnt = scnt_ff - 4'h1;
      end
    end
    if (emit) begin
      if (scnt_ff == 4'h0) begin
        nxt_sh   = {emit_val, 1'b1};
        nxt_scnt = `ISRP_SER_BITS;
      end else begin
        nxt_ovr = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sh_ff   <= 11'h000;
      scnt_ff <= 4'h0;
      ser_ff  <= 1'b0;
      ovr_ff  <= 1'b0;
      ph_ff   <= 1'b0;
      sck_ff  <= 1'b0;
    end else begin
      sh_ff   <= nxt_sh;
      scnt_ff <= nxt_scnt;
      ser_ff  <= nxt_ser;
      ovr_ff  <= nxt_ovr;
      ph_ff   <= ~ph_ff;
      sck_ff  <= ph_ff ? ~sck_ff : sck_ff;  // [R8]
    end
  end
  assign serial_pixel_out_p   = ser_ff;
  assign serial_pixel_out_n   = ~ser_ff;
  assign serial_shift_clock_p = sck_ff;
  assign serial_shift_clock_n = ~sck_ff;

  // checks
  sequence s_quiet;
    !ev;
  endsequence
  a_valid_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pix_ff.lval |-> pix_ff.fval) else $error("line valid without frame valid");  // [R4]
  a_blank_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pix_ff.lval |-> pix_ff.data == 10'h000) else $error("data not zero in blanking");  // [R4]
  a_data_steady: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_quiet |=> $stable(pix_ff)) else $error("pixel output moved off a master edge");  // [R5]
  a_pclk_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ev && !ctrl_ff.bin2) |=> !pclk_ff) else $error("pixel clock not low after update");  // [R5]
  a_pclk_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pclk_ff |-> ##[1:64] !pclk_ff) else $error("pixel clock stopped");  // [R20]
  a_oe_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n, 3) |-> pix_data_oe == $past(out_enable, 3))
    else $error("data enable not following pin");  // [R7]
  a_sync_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $stable(ctrl_ff.master) |=> line_start_sync_oe == $past(ctrl_ff.master) &&
    frame_start_sync_oe == $past(ctrl_ff.master))
    else $error("sync pin direction wrong");  // [R2] [R3]
  a_slave_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !line_start_sync_oe |-> !ls_o_ff && !fs_o_ff) else $error("slave drives sync");  // [R3]
  a_scan_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc_col_ff < `ISRP_NCOLS && sc_row_ff < `ISRP_NROWS) else $error("scan outside array");  // [R9]
  a_cal_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_ff == `ISRP_CAL_LAST && cal_q && ev |=> off_ff == $past(nxt_acc[17:8]))
    else $error("black level not loaded");  // [R11]
  a_serial_word: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (emit && scnt_ff == 4'h0) |=> scnt_ff == `ISRP_SER_BITS ##[1:2] serial_pixel_out_p)
    else $error("serial start bit missing");  // [R8]
endmodule

// File: testbench.sv
// self-checking bench: register port, raw readout of a black row, pins and serial link
`timescale 1ns/1ps
`include "isrp_params.svh"
module testbench;
  import isrp_pkg::*;
  logic        sys_clk, rst_n, master_clock_in, out_enable, clk_run, reg_wr, reg_rd;
  logic        line_start_sync_i, frame_start_sync_i, pixel_clock_out, pix_data_oe;
  logic        line_start_sync_o, line_start_sync_oe, frame_start_sync_o;
  logic        frame_start_sync_oe, serial_pixel_out_p, serial_pixel_out_n;
  logic        serial_shift_clock_p, serial_shift_clock_n;
  logic        lss_q, fss_q, shc_q, pck_q, start_seen;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, line_len, seq_err;
  logic [9:0]  adc_data, arr_col;
  logic [8:0]  arr_row;
  logic [3:0]  row_tag;
  isrp_pix_t   pix;
  int          n_fail, total_checks, bad_valid, bad_ser, blank_rise;
  int          n_line, n_frame, sh_tog, pck_tog, snap, i;

  isrp_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .master_clock_in(master_clock_in),
    .out_enable(out_enable), .line_start_sync_i(line_start_sync_i),
    .frame_start_sync_i(frame_start_sync_i), .adc_data(adc_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pix(pix), .pixel_clock_out(pixel_clock_out), .pix_data_oe(pix_data_oe),
    .line_start_sync_o(line_start_sync_o), .line_start_sync_oe(line_start_sync_oe),
    .frame_start_sync_o(frame_start_sync_o), .frame_start_sync_oe(frame_start_sync_oe),
    .serial_pixel_out_p(serial_pixel_out_p), .serial_pixel_out_n(serial_pixel_out_n),
    .serial_shift_clock_p(serial_shift_clock_p), .serial_shift_clock_n(serial_shift_clock_n),
    .arr_row(arr_row), .arr_col(arr_col));

  isrp_partner partner (.sys_clk(sys_clk), .clk_run(clk_run), .arr_row(arr_row),
    .arr_col(arr_col), .pix(pix), .pixel_clock_out(pixel_clock_out),
    .master_clock_in(master_clock_in), .adc_data(adc_data), .line_len(line_len),
    .row_tag(row_tag), .seq_err(seq_err));

  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, reg_rdata, exp);
  endtask

  // bounded wait on line valid; running out ends the run as a failure
  task automatic wait_lval(input logic v);
    int i;
    i = 0;
    while (pix.lval !== v && i < 30000) begin
      @(posedge sys_clk);
      i++;
    end
    if (i >= 30000) begin
      n_fail++;
      conclude();
    end
  endtask

  // continuous watch of valids, differential pairs, sync pulses and clock activity
  always @(posedge sys_clk) begin
    lss_q <= line_start_sync_o;
    fss_q <= frame_start_sync_o;
    shc_q <= serial_shift_clock_p;
    pck_q <= pixel_clock_out;
    if (rst_n) begin
      if ((pix.lval && !pix.fval) || (!pix.lval && pix.data !== 10'h000)) bad_valid++;
      if (serial_pixel_out_n !== ~serial_pixel_out_p) bad_ser++;
      if (serial_shift_clock_n !== ~serial_shift_clock_p) bad_ser++;
      if (serial_pixel_out_p === 1'b1) start_seen <= 1'b1;
      if (serial_shift_clock_p !== shc_q) sh_tog++;
      if (pixel_clock_out !== pck_q) pck_tog++;
      if (pixel_clock_out && !pck_q && !pix.lval) blank_rise++;
      if (line_start_sync_o && !lss_q) n_line++;
      if (frame_start_sync_o && !fss_q) n_frame++;
    end
  end

  // watchdog: the whole sequence needs about 51000 cycles
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end

  initial begin
    {rst_n, reg_wr, reg_rd, clk_run, line_start_sync_i, frame_start_sync_i} = 6'h00;
    {out_enable, start_seen, reg_addr, reg_wdata} = {1'b1, 1'b0, 8'h00, 16'h0000};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("pix after reset", {4'h0, pix}, 16'h0000);
    check("serial idle", {14'h0, serial_pixel_out_n, serial_shift_clock_n}, 16'h0003);
    check("pixel bus width", 16'($bits(pix.data)), 16'h000A);
    rd_chk(`ISRP_REG_CTRL, 16'h0041, "ctrl reset");
    @(posedge sys_clk);
    #1;
    check("rdata after its cycle", reg_rdata, 16'h0000);
    rd_chk(`ISRP_REG_BLC, 16'h0000, "black config reset");
    rd_chk(`ISRP_REG_FCNT, 16'h0000, "frame count reset");
    reg_write(8'h20, 16'hFFFF);
    rd_chk(8'h20, 16'h0000, "unmapped read");
    reg_write(`ISRP_REG_STAT, 16'hFFFF);
    rd_chk(`ISRP_REG_STAT, 16'h0000, "status read only");
    reg_write(`ISRP_REG_BLC, 16'h0004);
    rd_chk(`ISRP_REG_BLC, 16'h0004, "colour bit");
    reg_write(`ISRP_REG_BLC, 16'h0000);
    // raw mode brings the middle black rows out early, keeping the run short
    reg_write(`ISRP_REG_CTRL, 16'h0043);
    clk_run <= 1'b1;
    wait_lval(1'b1);
    check("pixel clock in blanking", {15'h0, blank_rise >= 1500}, 16'h0001);
    wait_lval(1'b0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("pixels per line", line_len, 16'(`ISRP_ACT_COLS - 10'h001));
    check("first raw row", {12'h0, row_tag}, {12'h0, 4'(`ISRP_RAW_ROW0)});
    check("pixel order and hold", seq_err, 16'h0000);
    check("valid framing", 16'(bad_valid), 16'h0000);
    check("line sync pulses", 16'(n_line), 16'h0003);
    check("frame sync pulses", 16'(n_frame), 16'h0001);
    check("serial pairs", 16'(bad_ser), 16'h0000);
    check("serial activity", {14'h0, start_seen, sh_tog > 100}, 16'h0003);
    // row 0 alternates 0x20/0x40, so the all-dark mean is 0x30; overrun is sticky
    rd_chk(`ISRP_REG_STAT, 16'h8030, "status after line");
    rd_chk(`ISRP_REG_STAT, 16'h0030, "status overrun cleared");
    // output enable low floats only the data pins
    @(posedge sys_clk);
    out_enable <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
    check("data oe off", {15'h0, pix_data_oe}, 16'h0000);
    snap = pck_tog;
    repeat (40) @(posedge sys_clk);
    #1;
    check("pixel clock kept", {15'h0, pck_tog > snap + 1}, 16'h0001);
    check("sync still driven", {14'h0, line_start_sync_oe, frame_start_sync_oe}, 16'h0003);
    @(posedge sys_clk);
    out_enable <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    check("data oe on", {15'h0, pix_data_oe}, 16'h0001);
    // restart as slave with the colour bit set; the disable needs a master edge to land
    reg_write(`ISRP_REG_CTRL, 16'h0000);
    repeat (40) @(posedge sys_clk);
    reg_write(`ISRP_REG_BLC, 16'h0004);
    reg_write(`ISRP_REG_CTRL, 16'h0042);
    repeat (64) @(posedge sys_clk);
    #1;
    check("sync oe in slave", {14'h0, line_start_sync_oe, frame_start_sync_oe}, 16'h0000);
    check("slave waits for frame sync", {6'h0, arr_col}, 16'h0000);
    @(posedge sys_clk);
    frame_start_sync_i <= 1'b1;
    // first 256 green pixels sit on odd columns of row 0, all at level 0x40
    repeat (8500) @(posedge sys_clk);
    rd_chk(`ISRP_REG_STAT, 16'h0040, "status colour offset");
    i = 0;
    while (arr_row !== 9'h001 && i < 9000) begin
      @(posedge sys_clk);
      i++;
    end
    repeat (64) @(posedge sys_clk);
    #1;
    check("slave waits for line sync", {arr_row[5:0], arr_col}, 16'h0400);
    @(posedge sys_clk);
    line_start_sync_i <= 1'b1;
    repeat (48) @(posedge sys_clk);
    #1;
    check("slave row started", {15'h0, arr_col != 10'h000}, 16'h0001);
    conclude();
  end
endmodule
